// ===== rtl/fcrp_regs.svh
// Constants for the coefficient reload port: register offsets, field positions, reset values.
// Assumes an AHB-Lite master with word-wide single transfers and a 12-bit register window.
// How it works
// R01: Address, write data, enable, read data, valid.
// R02: Read-only build reads; read/write build writes.
// R03: Port clock independent of filter clock.
// R04: Without reload option, no port access.
// R05: Reload accepted while samples keep flowing.
// R06: Master rewrites only after needed outputs.
// R07: Master pulses port reset before reloading.
// R08: Master reads back to verify reload.
// R09: New coefficients apply to next samples.
// R10: Symmetric filter maps unique coefficients only.
// R11: Addresses beyond unique range are ignored.
// R12: Banks placed back to back, ascending.
// R13: Non-symmetric banks follow at full length.
// R14: Write data 16 or 32 bits wide.
// R15: One coefficient written per enabled clock.
// R16: Read data qualified by read valid.
// R17: Write changes only the addressed coefficient.
// R18: Read returns coefficient at given address.
// R19: Idle bank rewritable while another filters.
// R20: Sample word carries bank in upper bits.
// R21: Read valid one port cycle, fixed latency.
// R22: Port reset clears port pipeline only.
`ifndef FCRP_REGS_SVH
`define FCRP_REGS_SVH

`define FCRP_CTRL_OFS      12'h000
`define FCRP_STAT_OFS      12'h004
`define FCRP_BANK_OFS      12'h008
`define FCRP_CTRL_WR_BIT   0
`define FCRP_CTRL_CLR_BIT  1
`define FCRP_CTRL_WR_RST   1'b1
`define FCRP_STAT_CNT_LSB  0
`define FCRP_STAT_CNT_W    16
`define FCRP_STAT_RV_BIT   16
`define FCRP_STAT_WE_BIT   17
`define FCRP_HRESP_OKAY    1'b0
`define FCRP_OFS_W         12

`endif

// ===== rtl/fcrp_pkg.sv
// Types shared by the coefficient reload port.
// Assumes fcrp_regs.svh is on the include path.
`include "fcrp_regs.svh"

package fcrp_pkg;

    // AHB-Lite address phase held over into the data phase
    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic [`FCRP_OFS_W-1:0] ofs;
    } fcrp_aph_t;

endpackage

// ===== rtl/fcrp_coef_port.sv
// Coefficient store of a FIR filter with its memory-mapped reload port and AHB-Lite registers.
// Assumes the port pins come from another clock domain; samples and taps run on i_sys_clk.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`include "fcrp_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module fcrp_coef_port import fcrp_pkg::*; #(
    parameter  int TAPS      = 37,
    parameter  int SYMM      = 1,
    parameter  int NBANK     = 4,
    parameter  int COEF_W    = 16,
    parameter  int XIN_W     = 8,
    parameter  int ADDR_W    = 8,
    parameter  int RELOAD_EN = 1,
    parameter  int WRITABLE  = 1,
    // R14: write data width
    localparam int WDATA_W   = (COEF_W > 16) ? 32 : 16,
    localparam int BANK_W    = (NBANK > 1) ? $clog2(NBANK) : 1
) (
    // Clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    // Coefficient port, foreign clock domain
    input  wire logic                      i_coef_clk,
    input  wire logic                      i_coef_areset,
    input  wire logic [ADDR_W-1:0]         i_coef_addr,
    input  wire logic [WDATA_W-1:0]        i_coef_wdata,
    input  wire logic                      i_coef_we,
    output logic      [WDATA_W-1:0]        o_coef_rdata,
    output logic                           o_coef_rvalid,
    // Sample input and tap lookup
    input  wire logic [BANK_W+XIN_W-1:0]   i_sample_word,
    input  wire logic                      i_sample_valid,
    input  wire logic [ADDR_W-1:0]         i_tap_idx,
    output logic      [XIN_W-1:0]          o_sample_x,
    output logic      [BANK_W-1:0]         o_sample_bank,
    output logic                           o_sample_valid,
    output logic      [COEF_W-1:0]         o_tap_coef,
    // AHB-Lite slave
    input  wire logic                      i_hsel,
    input  wire logic [31:0]               i_haddr,
    input  wire logic [1:0]                i_htrans,
    input  wire logic                      i_hwrite,
    input  wire logic [2:0]                i_hsize,
    input  wire logic [31:0]               i_hwdata,
    input  wire logic                      i_hready,
    output logic      [31:0]               o_hrdata,
    output logic                           o_hreadyout,
    output logic                           o_hresp
);

    // R10: only unique coefficients are stored
    localparam int UNIQ  = (SYMM != 0) ? (TAPS + 1) / 2 : TAPS;
    localparam int DEPTH = NBANK * UNIQ;
    localparam logic [ADDR_W:0]   DEPTH_V = (ADDR_W + 1)'(DEPTH);
    localparam logic [ADDR_W-1:0] UNIQ_V  = ADDR_W'(UNIQ);
    localparam logic [ADDR_W-1:0] TAPS_M1 = ADDR_W'(TAPS - 1);

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    typedef struct packed {
        logic                              clk_m;
        logic                              clk_s;
        logic                              clk_d;
        logic                              rst_m;
        logic                              rst_s;
        logic                              we_m;
        logic                              we_s;
        logic                              we_d;
        logic [ADDR_W-1:0]                 addr_m;
        logic [ADDR_W-1:0]                 addr_s;
        logic [ADDR_W-1:0]                 addr_d;
        logic [WDATA_W-1:0]                wdata_m;
        logic [WDATA_W-1:0]                wdata_s;
        logic [WDATA_W-1:0]                wdata_d;
        logic                              rvalid;
        logic [WDATA_W-1:0]                rdata;
        logic [DEPTH-1:0][COEF_W-1:0]      mem;
        logic [BANK_W-1:0]                 bank;
        logic [XIN_W-1:0]                  x;
        logic                              xv;
        logic [COEF_W-1:0]                 tap;
        fcrp_aph_t                         aph;
        logic [31:0]                       hrdata;
        logic                              wr_allow;
        logic [`FCRP_STAT_CNT_W-1:0]       wcnt;
    } fcrp_state_t;

    fcrp_state_t s;
    fcrp_state_t next_s;

    logic port_rise;
    logic rd_ok;
    logic wr_ok;
    logic ctrl_wr;
    logic cnt_clr;

    // R11: addresses past the last bank are not part of the space
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return {1'b0, a} < DEPTH_V;
    endfunction

    // R12: bank b starts at b times the unique count
    // R13: non-symmetric banks use the full tap count as stride
    function automatic logic [ADDR_W-1:0] tap_addr(input logic [BANK_W-1:0] b,
                                                  input logic [ADDR_W-1:0] i);
        logic [ADDR_W-1:0] f;
        f = (i >= UNIQ_V) ? (TAPS_M1 - i) : i;
        return ADDR_W'(b) * UNIQ_V + f;
    endfunction

    //--------------------------------------------------------------------
    // Port edge and access decode
    //--------------------------------------------------------------------
    // Limitation: each port clock phase must span two system cycles at least.
    // Pins are taken from the system edge just before the port edge, so they
    // must settle one system cycle early but may change right after that edge.
    // R03: port clock found by sampling, so the bus clock may be unrelated
    assign port_rise = s.clk_s & ~s.clk_d;
    // R04: without the option the port never reads
    // R02: reads allowed in either build
    assign rd_ok   = (RELOAD_EN != 0) && !s.we_d && mapped(s.addr_d);
    // R02: writes only in the read/write build
    // R15: one write per port edge with enable high
    assign wr_ok   = port_rise && !s.rst_s && (RELOAD_EN != 0) && (WRITABLE != 0)
                     && s.wr_allow && s.we_d && mapped(s.addr_d);
    assign ctrl_wr = s.aph.valid && s.aph.write && (s.aph.ofs == `FCRP_CTRL_OFS);
    assign cnt_clr = ctrl_wr && i_hwdata[`FCRP_CTRL_CLR_BIT];

    //--------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------
    always_comb begin
        next_s = s;
        // R01: port pins synchronised before use
        next_s.clk_m   = i_coef_clk;
        next_s.clk_s   = s.clk_m;
        next_s.clk_d   = s.clk_s;
        next_s.rst_m   = i_coef_areset;
        next_s.rst_s   = s.rst_m;
        next_s.we_m    = i_coef_we;
        next_s.we_s    = s.we_m;
        next_s.we_d    = s.we_s;
        next_s.addr_m  = i_coef_addr;
        next_s.addr_s  = s.addr_m;
        next_s.addr_d  = s.addr_s;
        next_s.wdata_m = i_coef_wdata;
        next_s.wdata_s = s.wdata_m;
        next_s.wdata_d = s.wdata_s;
        // Data taken one stage older than the clock, i.e. before the master's edge
        if (s.rst_s) begin
            // R22: port reset clears only the port pipeline
            next_s.rvalid = 1'b0;
            next_s.rdata  = '0;
        end else if (port_rise) begin
            // R21: valid set on a read port edge, held until the next port edge
            next_s.rvalid = rd_ok;
            if (rd_ok) begin
                // R18: addressed coefficient returned
                // R16: sign-extended onto the read data lanes
                next_s.rdata = WDATA_W'($signed(s.mem[s.addr_d]));
            end
        end
        if (wr_ok) begin
            // R17: only the addressed word changes
            next_s.mem[s.addr_d] = s.wdata_d[COEF_W-1:0];
        end
        // A clear and an increment in the same cycle leave the count at one
        if (cnt_clr) begin
            next_s.wcnt = '0;
        end
        if (wr_ok) begin
            next_s.wcnt = (cnt_clr ? '0 : s.wcnt) + 1'b1;
        end

        // R05: sample path never waits for the port
        // R20: bank in the upper bits, sample in the lower
        if (i_sample_valid) begin
            next_s.bank = (NBANK > 1) ? i_sample_word[XIN_W +: BANK_W] : '0;
            next_s.x    = i_sample_word[XIN_W-1:0];
        end
        next_s.xv  = i_sample_valid;
        // R09: a coefficient written now is seen by the next lookup
        // R19: the bank in use is whatever the last sample selected
        next_s.tap = s.mem[tap_addr(s.bank, i_tap_idx)];

        // AHB-Lite: zero wait states, read data fetched in the address phase
        if (i_hready) begin
            next_s.aph.valid = i_hsel && i_htrans[1];
            next_s.aph.write = i_hwrite;
            next_s.aph.ofs   = i_haddr[`FCRP_OFS_W-1:0];
            if (i_hsel && i_htrans[1] && !i_hwrite) begin
                next_s.hrdata = '0;
                case (i_haddr[`FCRP_OFS_W-1:0])
                    `FCRP_CTRL_OFS: begin
                        next_s.hrdata[`FCRP_CTRL_WR_BIT] = s.wr_allow;
                    end
                    `FCRP_STAT_OFS: begin
                        next_s.hrdata[`FCRP_STAT_CNT_LSB +: `FCRP_STAT_CNT_W] = s.wcnt;
                        next_s.hrdata[`FCRP_STAT_RV_BIT] = s.rvalid;
                        next_s.hrdata[`FCRP_STAT_WE_BIT] = s.we_s;
                    end
                    `FCRP_BANK_OFS: begin
                        next_s.hrdata = 32'(s.bank);
                    end
                    default: begin
                        next_s.hrdata = '0;
                    end
                endcase
            end
        end
        if (ctrl_wr) begin
            next_s.wr_allow = i_hwdata[`FCRP_CTRL_WR_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s          <= '0;
            s.wr_allow <= `FCRP_CTRL_WR_RST;
        end else begin
            s <= next_s;
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    assign o_coef_rdata   = s.rdata;
    assign o_coef_rvalid  = s.rvalid;
    assign o_sample_x     = s.x;
    assign o_sample_bank  = s.bank;
    assign o_sample_valid = s.xv;
    assign o_tap_coef     = s.tap;
    assign o_hrdata       = s.hrdata;
    assign o_hreadyout    = 1'b1;
    assign o_hresp        = `FCRP_HRESP_OKAY;

    //--------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // Port-side properties are timed from the detected edge, not the pin,
    // so they hold for any port clock slower than four system cycles.

    rvalid_set_a: assert property (port_rise && !s.rst_s && rd_ok |=> o_coef_rvalid // R21
                                   ##1 (o_coef_rvalid || s.rst_s || port_rise))
        else $error("read valid not raised for one port cycle");

    no_option_a: assert property ((RELOAD_EN == 0) |-> !o_coef_rvalid && !wr_ok) // R04
        else $error("port active without reload option");

    ro_build_a: assert property ((WRITABLE == 0) |=> $stable(s.mem)) // R02
        else $error("coefficient changed in read-only build");

    write_one_a: assert property (wr_ok |=> // R17
                                  s.mem[$past(s.addr_d)] == $past(s.wdata_d[COEF_W-1:0]))
        else $error("addressed coefficient not written");

    unmapped_ign_a: assert property (port_rise && !mapped(s.addr_d) |=> // R11
                                     $stable(s.mem) && !o_coef_rvalid)
        else $error("unmapped address took effect");

    read_data_a: assert property (port_rise && !s.rst_s && rd_ok |=> // R18
                                  o_coef_rdata == WDATA_W'($signed($past(s.mem[s.addr_d]))))
        else $error("read data differs from stored coefficient");

    bank_sel_a: assert property (i_sample_valid && (NBANK > 1) |=> // R20
                                 o_sample_bank == $past(i_sample_word[XIN_W +: BANK_W]))
        else $error("bank not taken from sample word");

    port_reset_a: assert property (s.rst_s |=> !o_coef_rvalid && o_coef_rdata == '0) // R22
        else $error("port reset did not clear read pipeline");

    write_count_a: assert property (wr_ok && !cnt_clr |=> s.wcnt == $past(s.wcnt) + 1'b1) // R15
        else $error("write count did not step");

    tap_new_a: assert property (wr_ok ##1 (tap_addr(s.bank, i_tap_idx) == $past(s.addr_d)) // R09
                                |=> o_tap_coef == $past(s.wdata_d[COEF_W-1:0], 2))
        else $error("tap lookup missed new coefficient");

    mem_quiet_a: assert property (!wr_ok |=> $stable(s.mem)) // R17
        else $error("coefficient changed without a write");

    rvalid_drop_a: assert property (port_rise && !rd_ok |=> !o_coef_rvalid) // R21
        else $error("read valid outlived its port cycle");

    rvalid_rise_a: assert property ($rose(o_coef_rvalid) |-> $past(port_rise && rd_ok)) // R21
        else $error("read valid rose without a read edge");

    unmapped_cnt_a: assert property (port_rise && !mapped(s.addr_d) && !cnt_clr |=> // R11
                                     s.wcnt == $past(s.wcnt))
        else $error("unmapped write was counted");

    sample_flow_a: assert property (i_sample_valid |=> o_sample_valid) // R05
        else $error("sample path stalled");

endmodule // fcrp_coef_port

`default_nettype wire

// ===== test/fcrp_port_master.sv
// Behavioural bus master on the coefficient port, with its own port clock.
// Assumes the bench owns i_sys_clk; port edges are kept off its rising edges.
`timescale 1ns/100ps
`default_nettype none

module fcrp_port_master (
    // Observed
    input  wire logic        i_sys_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid,
    // Driven
    output var logic         o_clk,
    output var logic         o_areset,
    output var logic  [7:0]  o_addr,
    output var logic  [15:0] o_wdata,
    output var logic         o_we
);
    // Response seen just before each port edge, so entry k answers request k-1
    logic [16:0] rsp_q[$];

    initial begin
        o_clk = 1'b0;
        o_areset = 1'b0;
        o_addr = 8'hff;
        o_wdata = 16'h0;
        o_we = 1'b0;
    end

    // Offset of 1 ns keeps port edges away from system clock edges
    task automatic start();
        rsp_q.delete();
        @(posedge i_sys_clk);
        #1;
    endtask

    task automatic pulse_rst();
        @(posedge i_sys_clk);
        #1 o_areset = 1'b1;
        #64 o_areset = 1'b0;
        #32;
    endtask

    task automatic req(input logic w, input logic [7:0] a, input logic [15:0] d);
        o_we = w;
        o_addr = a;
        o_wdata = d;
        #16 rsp_q.push_back({i_rvalid, i_rdata});
        o_clk = 1'b1;
        #16 o_clk = 1'b0;
    endtask

    // Every edge is a request: the frame ends on a refused address, clock then still
    task automatic close();
        req(1'b0, 8'hff, ~o_wdata);
    endtask
endmodule // fcrp_port_master

`default_nettype wire

// ===== test/fcrp_coef_port_tb_top.sv
// Self-checking bench for the coefficient reload port: default, read-only and no-reload builds.
// Assumes the design files under rtl/ are compiled first.
`timescale 1ns/100ps
`default_nettype none

module fcrp_coef_port_tb_top;
    localparam int UNIQ = 19;
    localparam int DEPTH = 76;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        coef_clk, coef_areset, coef_we, coef_rvalid, sample_v, hreadyout, hresp;
    logic [7:0]  coef_addr, sample_x;
    logic [15:0] coef_wdata, coef_rdata, tap_coef;
    logic [15:0] ro_tap, off_tap;
    logic [1:0]  sample_bank;
    logic [9:0]  sample_word = 10'h0;
    logic        sample_valid = 1'b0;
    logic [7:0]  tap_idx = 8'h0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [15:0] mem [DEPTH] = '{default: 16'h0};
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #2 sys_clk = ~sys_clk;

    fcrp_coef_port uut (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_coef_clk(coef_clk),
        .i_coef_areset(coef_areset), .i_coef_addr(coef_addr), .i_coef_wdata(coef_wdata),
        .i_coef_we(coef_we), .o_coef_rdata(coef_rdata), .o_coef_rvalid(coef_rvalid),
        .i_sample_word(sample_word), .i_sample_valid(sample_valid), .i_tap_idx(tap_idx),
        .o_sample_x(sample_x), .o_sample_bank(sample_bank), .o_sample_valid(sample_v),
        .o_tap_coef(tap_coef), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp)
    );

    fcrp_port_master m (
        .i_sys_clk(sys_clk), .i_rdata(coef_rdata), .i_rvalid(coef_rvalid),
        .o_clk(coef_clk), .o_areset(coef_areset), .o_addr(coef_addr),
        .o_wdata(coef_wdata), .o_we(coef_we)
    );

    // Read-only build on the same pins: its store must stay at zero
    fcrp_coef_port #(.WRITABLE(0)) uut_ro (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_coef_clk(coef_clk),
        .i_coef_areset(coef_areset), .i_coef_addr(coef_addr), .i_coef_wdata(coef_wdata),
        .i_coef_we(coef_we), .o_coef_rdata(), .o_coef_rvalid(),
        .i_sample_word(sample_word), .i_sample_valid(sample_valid), .i_tap_idx(tap_idx),
        .o_sample_x(), .o_sample_bank(), .o_sample_valid(), .o_tap_coef(ro_tap),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(), .o_hreadyout(), .o_hresp()
    );

    // Build without the reload option: the port must stay dead
    fcrp_coef_port #(.RELOAD_EN(0)) uut_off (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_coef_clk(coef_clk),
        .i_coef_areset(coef_areset), .i_coef_addr(coef_addr), .i_coef_wdata(coef_wdata),
        .i_coef_we(coef_we), .o_coef_rdata(), .o_coef_rvalid(),
        .i_sample_word(sample_word), .i_sample_valid(sample_valid), .i_tap_idx(tap_idx),
        .o_sample_x(), .o_sample_bank(), .o_sample_valid(), .o_tap_coef(off_tap),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(), .o_hreadyout(), .o_hresp()
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(d, exp);
    endtask

    // Folded tap lookup: coefficient comes from the bank carried in the sample word
    task automatic tap(input int b, input int i);
        logic [7:0] x;
        int k;
        x = 8'($urandom);
        k = b * UNIQ + ((i >= UNIQ) ? 36 - i : i);
        @(posedge sys_clk);
        sample_word <= {2'(b), x};
        sample_valid <= 1'b1;
        tap_idx <= 8'(i);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({16'h0, tap_coef}, {16'h0, mem[k]});
        chk({21'h0, sample_v, sample_bank, sample_x}, {21'h1, 2'(b), x});
        chk({16'h0, ro_tap}, 32'h0);
        chk({16'h0, off_tap}, 32'h0);
    endtask

    // Hang guard: far above the fewer than two thousand cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [16:0] r;
        int taps[5] = '{0, 18, 19, 36, 7};
        void'($urandom(47));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(32'h0, 32'h1);
        rd_chk(32'h4, 32'h0);
        rd_chk(32'h8, 32'h0);
        rd_chk(32'hc, 32'h0);
        $display("test registers done");
        ahb(1'b1, 32'h0, 32'h0, d);
        m.pulse_rst();
        m.start();
        m.req(1'b1, 8'd5, 16'h1234);
        m.req(1'b0, 8'd5, 16'h0);
        m.close();
        chk({15'h0, m.rsp_q[2]}, 32'h10000);
        rd_chk(32'h4, 32'h0);
        $display("test blocked write done");
        ahb(1'b1, 32'h0, 32'h3, d);
        m.pulse_rst();
        m.start();
        for (int a = 0; a < DEPTH; a++) begin
            mem[a] = 16'($urandom);
            m.req(1'b1, 8'(a), mem[a]);
        end
        for (int a = 0; a < DEPTH + 4; a++) begin
            m.req(1'b0, 8'(a), 16'h0);
        end
        m.close();
        for (int a = 0; a < DEPTH + 4; a++) begin
            r = m.rsp_q[DEPTH + a + 1];
            if (a < DEPTH)
                chk({15'h0, r}, {16'h1, mem[a]});
            else
                chk({31'h0, r[16]}, 32'h0);
        end
        rd_chk(32'h4, 32'd76);
        for (int b = 0; b < 4; b++) begin
            for (int j = 0; j < 5; j++) begin
                tap(b, taps[j]);
            end
        end
        $display("test full reload done");
        tap(0, 7);
        m.pulse_rst();
        m.start();
        mem[7] = 16'd123;
        m.req(1'b1, 8'd7, 16'd123);
        for (int a = 6; a < 9; a++) begin
            m.req(1'b0, 8'(a), 16'h0);
        end
        m.close();
        for (int a = 6; a < 9; a++) begin
            chk({15'h0, m.rsp_q[a - 4]}, {16'h1, mem[a]});
        end
        tap(0, 7);
        $display("test single write done");
        // bank 1 is idle here, so none of its old outputs are still wanted
        fork
            begin
                m.pulse_rst();
                m.start();
                for (int a = UNIQ; a < 2 * UNIQ; a++) begin
                    mem[a] = 16'($urandom);
                    m.req(1'b1, 8'(a), mem[a]);
                end
                m.close();
            end
            repeat (40) tap(0, $urandom_range(36, 0));
        join
        repeat (8) tap(1, $urandom_range(36, 0));
        $display("test bank switch done");
        conclude();
    end
endmodule // fcrp_coef_port_tb_top

`default_nettype wire
